// *** hdl/tmr16_top.sv ***
/*
 * 16-bit up-counting timer with two capture/compare registers, free-running
 * and pulse generator modes, capture from two edge pins and a toggle output.
 * assumes a plain register port: strobes one cycle, read data one cycle later.
 */
`timescale 1ns/1ns
module tmr16_top (
   input  wire logic        sys_clk_in,
   input  wire logic        rstn_in,
   input  wire logic [7:0]  addr_in,
   input  wire logic [31:0] wr_data_in,
   input  wire logic        wr_en_in,
   input  wire logic        rd_en_in,
   output logic [31:0]      rd_data_out,
   input  wire logic        primary_edge_input_in,
   input  wire logic        secondary_edge_input_in,
   output logic             toggle_output_pin_out,
   output logic             match_irq_a_out,
   output logic             match_irq_b_out,
   output logic             overflow_flag_out
);
   tmr16_pkg::tmr16_ctrl_t ctrl_ff;
   logic [15:0]            timer_count_value_ff;
   logic [15:0]            capture_compare_a_ff;
   logic [15:0]            capture_compare_b_ff;
   logic                   tick;
   logic                   pri_edge;
   logic                   sec_edge;
   logic                   running;
   logic                   is_free;
   logic                   is_ppg;
   logic                   match_a;
   logic                   match_b;
   logic                   cap_a;
   logic                   cap_b;
   logic                   wrap;
   logic                   sec_in_use;
   logic                   toggle_evt;
   logic [15:0]            nxt_count;
   logic                   nxt_pin;

   function automatic logic cmp_hit(input logic is_cap, input logic [15:0] cc,
                                    input logic [15:0] cnt, input logic tk);
      cmp_hit = tk & ~is_cap & (cc == cnt);
   endfunction

   function automatic logic wr_hit(input logic en, input logic [7:0] a,
                                   input logic [7:0] ofs);
      wr_hit = en & (a == ofs);
   endfunction

   assign is_free = (ctrl_ff.op_mode == tmr16_pkg::OP_FREE);
   assign is_ppg  = (ctrl_ff.op_mode == tmr16_pkg::OP_PPG);
   assign running = is_free | is_ppg;

   tmr16_prescaler u_presc (
      .sys_clk_in (sys_clk_in),
      .rstn_in    (rstn_in),
      .run_in     (running),
      .clk_sel_in (ctrl_ff.clk_sel),
      .tick_out   (tick)
   );

   tmr16_edge_det u_pri (
      .sys_clk_in  (sys_clk_in),
      .rstn_in     (rstn_in),
      .pin_in      (primary_edge_input_in),
      .edge_sel_in (ctrl_ff.pri_edge),
      .edge_out    (pri_edge)
   );

   tmr16_edge_det u_sec (
      .sys_clk_in  (sys_clk_in),
      .rstn_in     (rstn_in),
      .pin_in      (secondary_edge_input_in),
      .edge_sel_in (ctrl_ff.sec_edge),
      .edge_out    (sec_edge)
   );

   // match is seen on the tick that would move the counter past the value
   assign match_a = running & cmp_hit(ctrl_ff.a_capture, capture_compare_a_ff,
                                      timer_count_value_ff, tick);
   assign match_b = running & cmp_hit(ctrl_ff.b_capture, capture_compare_b_ff,
                                      timer_count_value_ff, tick);
   assign cap_a   = running & ctrl_ff.a_capture &
                    (ctrl_ff.a_trig_sec ? sec_edge : pri_edge);
   assign cap_b   = running & ctrl_ff.b_capture & pri_edge;
   assign wrap    = is_free & tick & (timer_count_value_ff == tmr16_pkg::CNT_MAX);
   assign sec_in_use = ctrl_ff.a_capture & ctrl_ff.a_trig_sec &
                       (ctrl_ff.sec_edge != tmr16_pkg::EDGE_NONE);

   // counter
   always_comb begin
      nxt_count = timer_count_value_ff;
      if (running && tick) begin
         if (is_ppg && match_a) nxt_count = tmr16_pkg::CNT_ZERO;
         else                   nxt_count = timer_count_value_ff + 16'h0001;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) timer_count_value_ff <= tmr16_pkg::CNT_ZERO;
      else          timer_count_value_ff <= nxt_count;
   end

   // control registers
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl_ff <= tmr16_pkg::CTRL_RST;
      end else begin
         if (wr_hit(wr_en_in, addr_in, tmr16_pkg::OFS_MODE)) begin
            ctrl_ff.op_mode            <= wr_data_in[tmr16_pkg::MODE_OP_LSB +: 2];
            ctrl_ff.edge_toggle_enable <= wr_data_in[tmr16_pkg::MODE_ETOG_BIT];
         end
         if (wr_hit(wr_en_in, addr_in, tmr16_pkg::OFS_CCCTL)) begin
            ctrl_ff.a_capture  <= wr_data_in[tmr16_pkg::CC_A_CAP_BIT];
            ctrl_ff.a_trig_sec <= wr_data_in[tmr16_pkg::CC_A_SEC_BIT];
            ctrl_ff.b_capture  <= wr_data_in[tmr16_pkg::CC_B_CAP_BIT];
         end
         if (wr_hit(wr_en_in, addr_in, tmr16_pkg::OFS_OUTCTL)) begin
            ctrl_ff.out_en  <= wr_data_in[tmr16_pkg::OUT_EN_BIT];
            ctrl_ff.tog_sel <= wr_data_in[tmr16_pkg::OUT_SEL_LSB +: 2];
         end
         if (wr_hit(wr_en_in, addr_in, tmr16_pkg::OFS_PRESC)) begin
            ctrl_ff.clk_sel  <= wr_data_in[tmr16_pkg::PRE_CLK_LSB +: 2];
            ctrl_ff.pri_edge <= wr_data_in[tmr16_pkg::PRE_PRI_LSB +: 2];
            ctrl_ff.sec_edge <= wr_data_in[tmr16_pkg::PRE_SEC_LSB +: 2];
         end
      end
   end

   // capture wins over a software write in the same cycle
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         capture_compare_a_ff <= tmr16_pkg::CC_RST;
      end else if (cap_a) begin
         capture_compare_a_ff <= timer_count_value_ff;
      end else if (wr_hit(wr_en_in, addr_in, tmr16_pkg::OFS_CC_A)) begin
         capture_compare_a_ff <= wr_data_in[15:0];
      end
   end

   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         capture_compare_b_ff <= tmr16_pkg::CC_RST;
      end else if (cap_b) begin
         capture_compare_b_ff <= timer_count_value_ff;
      end else if (wr_hit(wr_en_in, addr_in, tmr16_pkg::OFS_CC_B)) begin
         capture_compare_b_ff <= wr_data_in[15:0];
      end
   end

   // overflow: the set beats a clear written in the same cycle
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         overflow_flag_out <= 1'b0;
      end else if (wrap) begin
         overflow_flag_out <= 1'b1;
      end else if (wr_hit(wr_en_in, addr_in, tmr16_pkg::OFS_MODE) &&
                   !wr_data_in[tmr16_pkg::MODE_OVF_BIT]) begin
         overflow_flag_out <= 1'b0;
      end
   end

   // interrupt pulses: match in compare role, edge in capture role
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         match_irq_a_out <= 1'b0;
         match_irq_b_out <= 1'b0;
      end else begin
         match_irq_a_out <= match_a | cap_a;
         match_irq_b_out <= match_b | cap_b;
      end
   end

   // toggle output
   always_comb begin
      toggle_evt = 1'b0;
      unique case (ctrl_ff.tog_sel)
         tmr16_pkg::TOG_A:  toggle_evt = match_a;
         tmr16_pkg::TOG_B:  toggle_evt = match_b;
         tmr16_pkg::TOG_AB: toggle_evt = match_a | match_b;
         default:           toggle_evt = 1'b0;
      endcase
      if (ctrl_ff.edge_toggle_enable && running && pri_edge) begin
         toggle_evt = 1'b1;
      end
   end

   always_comb begin
      nxt_pin = toggle_output_pin_out;
      if (!ctrl_ff.out_en || sec_in_use) begin
         nxt_pin = 1'b0;
      end else if (is_ppg) begin
         // high for counts 0..b, so width b+1 of a period a+1
         nxt_pin = (nxt_count <= capture_compare_b_ff);
      end else if (toggle_evt) begin
         nxt_pin = ~toggle_output_pin_out;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) toggle_output_pin_out <= 1'b0;
      else          toggle_output_pin_out <= nxt_pin;
   end

   // register read port, zero for unmapped addresses
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rd_data_out <= '0;
      end else if (rd_en_in) begin
         unique case (addr_in)
            tmr16_pkg::OFS_COUNT:  rd_data_out <= {16'h0000, timer_count_value_ff};
            tmr16_pkg::OFS_CC_A:   rd_data_out <= {16'h0000, capture_compare_a_ff};
            tmr16_pkg::OFS_CC_B:   rd_data_out <= {16'h0000, capture_compare_b_ff};
            tmr16_pkg::OFS_MODE:   rd_data_out <= {28'h0000000, ctrl_ff.op_mode,
                                                   ctrl_ff.edge_toggle_enable,
                                                   overflow_flag_out};
            tmr16_pkg::OFS_CCCTL:  rd_data_out <= {29'h00000000, ctrl_ff.b_capture,
                                                   ctrl_ff.a_trig_sec, ctrl_ff.a_capture};
            tmr16_pkg::OFS_OUTCTL: rd_data_out <= {29'h00000000, ctrl_ff.tog_sel,
                                                   ctrl_ff.out_en};
            tmr16_pkg::OFS_PRESC:  rd_data_out <= {26'h0000000, ctrl_ff.sec_edge,
                                                   ctrl_ff.pri_edge, ctrl_ff.clk_sel};
            default:               rd_data_out <= '0;
         endcase
      end else begin
         rd_data_out <= '0;
      end
   end

   // checks
   property p_count_read;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (rd_en_in && addr_in == tmr16_pkg::OFS_COUNT) |=>
         rd_data_out == {16'h0000, $past(timer_count_value_ff)};
   endproperty
   a_count_read: assert property (p_count_read) else $error("count read wrong");

   property p_irq_a;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (running && tick && !ctrl_ff.a_capture &&
       timer_count_value_ff == capture_compare_a_ff) |=> match_irq_a_out;
   endproperty
   a_irq_a: assert property (p_irq_a) else $error("missing a match pulse");

   property p_irq_b;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (running && tick && !ctrl_ff.b_capture &&
       timer_count_value_ff == capture_compare_b_ff) |=> match_irq_b_out;
   endproperty
   a_irq_b: assert property (p_irq_b) else $error("missing b match pulse");

   property p_no_clear_free;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (is_free && tick && timer_count_value_ff != tmr16_pkg::CNT_MAX) |=>
         timer_count_value_ff == $past(timer_count_value_ff) + 16'h0001;
   endproperty
   a_no_clear_free: assert property (p_no_clear_free) else $error("count skipped");

   property p_cap_a;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      cap_a |=> capture_compare_a_ff == $past(timer_count_value_ff);
   endproperty
   a_cap_a: assert property (p_cap_a) else $error("a capture lost");

   property p_cap_b;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (running && ctrl_ff.b_capture && pri_edge) |=>
         capture_compare_b_ff == $past(timer_count_value_ff) && match_irq_b_out;
   endproperty
   a_cap_b: assert property (p_cap_b) else $error("b capture lost");

   property p_wrap;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (is_free && tick && timer_count_value_ff == tmr16_pkg::CNT_MAX) |=>
         overflow_flag_out && timer_count_value_ff == tmr16_pkg::CNT_ZERO;
   endproperty
   a_wrap: assert property (p_wrap) else $error("overflow wrap wrong");

   property p_ovf_sticky;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (overflow_flag_out && !wr_hit(wr_en_in, addr_in, tmr16_pkg::OFS_MODE)) |=>
         overflow_flag_out;
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow dropped");

   property p_ppg_clear;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (is_ppg && tick && !ctrl_ff.a_capture &&
       timer_count_value_ff == capture_compare_a_ff) |=>
         timer_count_value_ff == tmr16_pkg::CNT_ZERO;
   endproperty
   a_ppg_clear: assert property (p_ppg_clear) else $error("no clear on a match");

   property p_hold;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (!running || !tick) |=> $stable(timer_count_value_ff);
   endproperty
   a_hold: assert property (p_hold) else $error("count moved without tick");

   property p_sec_pin;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      sec_in_use[*2] |-> !toggle_output_pin_out;
   endproperty
   a_sec_pin: assert property (p_sec_pin) else $error("pin driven in secondary use");

   // select must have been none for a cycle, since the edge pulse is registered
   property p_b_kept;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (ctrl_ff.b_capture && ctrl_ff.pri_edge == tmr16_pkg::EDGE_NONE &&
       $past(ctrl_ff.pri_edge) == tmr16_pkg::EDGE_NONE &&
       !wr_hit(wr_en_in, addr_in, tmr16_pkg::OFS_CC_B)) |=> $stable(capture_compare_b_ff);
   endproperty
   a_b_kept: assert property (p_b_kept) else $error("b loaded without primary edges");

   property p_ppg_pin;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (is_ppg && ctrl_ff.out_en && !sec_in_use) |=>
         toggle_output_pin_out == (timer_count_value_ff <= $past(capture_compare_b_ff));
   endproperty
   a_ppg_pin: assert property (p_ppg_pin) else $error("pulse level wrong");

   property p_tog_b;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (!is_ppg && ctrl_ff.out_en && !sec_in_use && ctrl_ff.tog_sel[1] && match_b &&
       !(ctrl_ff.edge_toggle_enable && pri_edge)) |=>
         toggle_output_pin_out != $past(toggle_output_pin_out);
   endproperty
   a_tog_b: assert property (p_tog_b) else $error("no toggle on b match");
endmodule

// *** hdl/tmr16_pkg.sv ***
/*
 * shared constants and carrier types of the 16-bit capture/compare timer.
 * assumes a byte address port of 8 bits and a 32-bit read/write data word.
 */
package tmr16_pkg;
   localparam int unsigned AW          = 8;
   localparam int unsigned DW          = 32;
   localparam int unsigned CW          = 16;
   localparam logic [7:0]  OFS_COUNT   = 8'h00;
   localparam logic [7:0]  OFS_CC_A    = 8'h04;
   localparam logic [7:0]  OFS_CC_B    = 8'h08;
   localparam logic [7:0]  OFS_MODE    = 8'h0c;
   localparam logic [7:0]  OFS_CCCTL   = 8'h10;
   localparam logic [7:0]  OFS_OUTCTL  = 8'h14;
   localparam logic [7:0]  OFS_PRESC   = 8'h18;
   // timer_mode_control fields
   localparam int unsigned MODE_OVF_BIT   = 0;
   localparam int unsigned MODE_ETOG_BIT  = 1;
   localparam int unsigned MODE_OP_LSB    = 2;
   // capture_compare_control fields
   localparam int unsigned CC_A_CAP_BIT   = 0;
   localparam int unsigned CC_A_SEC_BIT   = 1;
   localparam int unsigned CC_B_CAP_BIT   = 2;
   // output_control fields
   localparam int unsigned OUT_EN_BIT     = 0;
   localparam int unsigned OUT_SEL_LSB    = 1;
   // prescaler_mode fields
   localparam int unsigned PRE_CLK_LSB    = 0;
   localparam int unsigned PRE_PRI_LSB    = 2;
   localparam int unsigned PRE_SEC_LSB    = 4;
   // encodings
   localparam logic [1:0]  OP_STOP     = 2'h0;
   localparam logic [1:0]  OP_FREE     = 2'h1;
   localparam logic [1:0]  OP_PPG      = 2'h3;
   localparam logic [1:0]  TOG_A       = 2'h1;
   localparam logic [1:0]  TOG_B       = 2'h2;
   localparam logic [1:0]  TOG_AB      = 2'h3;
   localparam logic [1:0]  EDGE_FALL   = 2'h0;
   localparam logic [1:0]  EDGE_RISE   = 2'h1;
   localparam logic [1:0]  EDGE_NONE   = 2'h2;
   localparam logic [1:0]  EDGE_BOTH   = 2'h3;
   localparam logic [15:0] CNT_MAX     = 16'hffff;
   localparam logic [15:0] CNT_ZERO    = 16'h0000;
   localparam logic [15:0] CC_RST      = 16'h0000;
   localparam int unsigned PRE_W       = 3;
   localparam logic [1:0]  PRE_RST     = 2'h0;

   typedef struct packed {
      logic [1:0] op_mode;
      logic       edge_toggle_enable;
      logic       a_capture;
      logic       a_trig_sec;
      logic       b_capture;
      logic       out_en;
      logic [1:0] tog_sel;
      logic [1:0] clk_sel;
      logic [1:0] pri_edge;
      logic [1:0] sec_edge;
   } tmr16_ctrl_t;

   localparam tmr16_ctrl_t CTRL_RST = '{op_mode: OP_STOP, pri_edge: EDGE_NONE,
                                        sec_edge: EDGE_NONE, default: '0};
endpackage

// *** hdl/tmr16_edge_det.sv ***
/*
 * synchroniser and valid-edge detector for one timer input pin.
 * assumes the pin is asynchronous to sys_clk_in; pulse is one cycle long.
 */
`timescale 1ns/1ns
module tmr16_edge_det (
   input  wire logic       sys_clk_in,
   input  wire logic       rstn_in,
   input  wire logic       pin_in,
   input  wire logic [1:0] edge_sel_in,
   output logic            edge_out
);
   logic sync1_ff;
   logic sync2_ff;
   logic prev_ff;
   logic nxt_edge;

   // first stage is read only by the second stage
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         prev_ff  <= 1'b0;
      end else begin
         sync1_ff <= pin_in;
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
      end
   end

   always_comb begin
      unique case (edge_sel_in)
         tmr16_pkg::EDGE_FALL: nxt_edge = prev_ff & ~sync2_ff;
         tmr16_pkg::EDGE_RISE: nxt_edge = ~prev_ff & sync2_ff;
         tmr16_pkg::EDGE_BOTH: nxt_edge = prev_ff ^ sync2_ff;
         default:              nxt_edge = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) edge_out <= 1'b0;
      else          edge_out <= nxt_edge;
   end
endmodule

// *** hdl/tmr16_prescaler.sv ***
/*
 * count clock prescaler: one-cycle tick every 1, 2, 4 or 8 system clocks.
 * assumes the select is stable while counting; a change keeps the phase unless it already reaches the new mask; a stop or a reset clears it.
 */
`timescale 1ns/1ns
module tmr16_prescaler (
   input  wire logic       sys_clk_in,
   input  wire logic       rstn_in,
   input  wire logic       run_in,
   input  wire logic [1:0] clk_sel_in,
   output logic            tick_out
);
   logic [tmr16_pkg::PRE_W-1:0] div_ff;
   logic [tmr16_pkg::PRE_W-1:0] mask;

   assign mask = tmr16_pkg::PRE_W'((1 << clk_sel_in) - 1);

   // ticks only while running, so a stopped counter holds
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         div_ff   <= '0;
         tick_out <= 1'b0;
      end else if (!run_in) begin
         div_ff   <= '0;
         tick_out <= 1'b0;
      end else begin
         div_ff   <= (div_ff >= mask) ? '0 : div_ff + 1'b1;
         tick_out <= (div_ff >= mask);
      end
   end
endmodule

// *** verification/tmr16_pin_model.sv ***
/*
 * pin-side partner of the timer: drives both edge pins and counts toggles of the output pin.
 * assumes one-cycle requests from the bench on sys_clk_in; pins rest low after reset.
 */
`timescale 1ns/1ns
module tmr16_pin_model (
   input  wire logic        sys_clk_in,
   input  wire logic        rstn_in,
   input  wire logic        pri_req_in,
   input  wire logic        sec_req_in,
   input  wire logic        tog_pin_in,
   output logic             pri_pin_out,
   output logic             sec_pin_out,
   output logic [15:0]      tog_cnt_out
);
   logic tog_last_ff;

   // each request flips the pin, so with both edges selected every request is a valid edge
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pri_pin_out <= 1'b0;
         sec_pin_out <= 1'b0;
      end else begin
         pri_pin_out <= pri_pin_out ^ pri_req_in;
         sec_pin_out <= sec_pin_out ^ sec_req_in;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tog_last_ff <= 1'b0;
         tog_cnt_out <= 16'h0000;
      end else begin
         tog_last_ff <= tog_pin_in;
         if (tog_pin_in !== tog_last_ff) begin
            tog_cnt_out <= tog_cnt_out + 16'h0001;
         end
      end
   end
endmodule

// *** verification/tmr16_top_tb.sv ***
/*
 * self-checking bench of the 16-bit capture/compare timer: register tasks and scenarios.
 * assumes the pin partner model and a count clock of sys/1 in every scenario.
 */
`timescale 1ns/1ns
module tmr16_top_tb;
   logic        sys_clk_in, rstn_in, wr_en_in, rd_en_in, pri_req, sec_req;
   logic        pri_pin, sec_pin, tog_pin, irq_a, irq_b, ovf;
   logic [7:0]  addr_in;
   logic [31:0] wr_data_in, rd_data_out, rd_q, cnt_q, sv_b;
   logic [15:0] tog_cnt, t0;
   int          num_errors, tests_run, cyc, n, h;

   tmr16_top tmr16_top_inst (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
      .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
      .rd_data_out(rd_data_out), .primary_edge_input_in(pri_pin),
      .secondary_edge_input_in(sec_pin), .toggle_output_pin_out(tog_pin),
      .match_irq_a_out(irq_a), .match_irq_b_out(irq_b), .overflow_flag_out(ovf));
   tmr16_pin_model tmr16_pin_model_inst (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
      .pri_req_in(pri_req), .sec_req_in(sec_req), .tog_pin_in(tog_pin),
      .pri_pin_out(pri_pin), .sec_pin_out(sec_pin), .tog_cnt_out(tog_cnt));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // idle edge after each write, so back-to-back writes never set the strobe twice in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr_in <= a;
      wr_data_in <= d;
      wr_en_in <= 1'b1;
      @(posedge sys_clk_in);
      wr_en_in <= 1'b0;
      @(posedge sys_clk_in);
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      addr_in <= a;
      rd_en_in <= 1'b1;
      @(posedge sys_clk_in);
      rd_en_in <= 1'b0;
      @(posedge sys_clk_in);
      rd_q = rd_data_out;
   endtask

   task automatic wait_ev(input int which, input int lim);
      logic [2:0] ev;
      n = 0;
      ev = 3'h0;
      while (ev[which] !== 1'b1 && n < lim) begin
         @(posedge sys_clk_in);
         ev = {ovf, irq_b, irq_a};
         n++;
      end
      chk("event seen", 32'h1, {31'h0, ev[which]});
   endtask

   // capture came from the cycle before the pulse; the count read follows one cycle after it
   task automatic cap(input int which, input logic [7:0] ofs);
      wait_ev(which, 40);
      rd(tmr16_pkg::OFS_COUNT);
      cnt_q = rd_q;
      rd(ofs);
      chk("captured count", cnt_q - 32'h2, rd_q);
   endtask

   task automatic pulse(input logic sec);
      if (sec) begin
         sec_req <= 1'b1;
      end else begin
         pri_req <= 1'b1;
      end
      @(posedge sys_clk_in);
      pri_req <= 1'b0;
      sec_req <= 1'b0;
   endtask

   task automatic run_len(input logic lvl);
      n = 0;
      do begin
         @(posedge sys_clk_in);
         n++;
      end while (tog_pin === lvl && n < 100);
   endtask

   task automatic report_and_stop();
      if (num_errors == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end

   // the long wait is one wrap of the counter at sys/1
   initial begin
      cyc = 0;
      forever begin
         @(posedge sys_clk_in);
         cyc++;
         if (cyc == 90000) begin
            num_errors++;
            report_and_stop();
         end
      end
   end

   initial begin
      num_errors = 0;
      tests_run = 0;
      {rstn_in, wr_en_in, rd_en_in, pri_req, sec_req} = 5'h00;
      addr_in = 8'h00;
      wr_data_in = 32'h0;
      repeat (2) @(posedge sys_clk_in);
      rstn_in <= 1'b1;
      @(posedge sys_clk_in);
      rd(tmr16_pkg::OFS_CC_B);
      chk("cc b reset", 32'h0, rd_q);
      wr(tmr16_pkg::OFS_COUNT, 32'h5);
      rd(tmr16_pkg::OFS_COUNT);
      chk("count read only", 32'h0, rd_q);
      rd(8'h1c);
      chk("unmapped", 32'h0, rd_q);
      wr(tmr16_pkg::OFS_CC_A, 32'hffff_1234);
      rd(tmr16_pkg::OFS_CC_A);
      chk("cc a width", 32'h1234, rd_q);
      wr(tmr16_pkg::OFS_PRESC, 32'h28);
      for (int s = 1; s < 4; s++) begin
         wr(tmr16_pkg::OFS_MODE, 32'h0);
         rd(tmr16_pkg::OFS_COUNT);
         cnt_q = rd_q;
         rd(tmr16_pkg::OFS_COUNT);
         chk("held count", cnt_q, rd_q);
         wr(tmr16_pkg::OFS_CC_A, cnt_q + 32'h10);
         wr(tmr16_pkg::OFS_CC_B, cnt_q + 32'h20);
         wr(tmr16_pkg::OFS_OUTCTL, {29'h0, s[1:0], 1'b1});
         t0 = tog_cnt;
         wr(tmr16_pkg::OFS_MODE, 32'h4);
         wait_ev(0, 40);
         rd(tmr16_pkg::OFS_COUNT);
         chk("count past a match", cnt_q + 32'h12, rd_q);
         chk("toggles at a", s[0], {16'h0, tog_cnt - t0});
         wait_ev(1, 40);
         repeat (3) @(posedge sys_clk_in);
         chk("toggles at b", s[0] + s[1], {16'h0, tog_cnt - t0});
      end
      wr(tmr16_pkg::OFS_OUTCTL, 32'h0);
      wait_ev(2, 70000);
      rd(tmr16_pkg::OFS_COUNT);
      chk("count after wrap", 32'h1, rd_q);
      rd(tmr16_pkg::OFS_MODE);
      chk("sticky overflow", 32'h5, rd_q);
      wr(tmr16_pkg::OFS_MODE, 32'h4);
      @(posedge sys_clk_in);
      chk("overflow cleared", 32'h0, {31'h0, ovf});
      wr(tmr16_pkg::OFS_PRESC, 32'h24);
      wr(tmr16_pkg::OFS_CCCTL, 32'h4);
      pulse(1'b0);
      cap(1, tmr16_pkg::OFS_CC_B);
      wr(tmr16_pkg::OFS_CCCTL, 32'h5);
      wr(tmr16_pkg::OFS_PRESC, 32'h20);
      wr(tmr16_pkg::OFS_OUTCTL, 32'h1);
      wr(tmr16_pkg::OFS_MODE, 32'h6);
      t0 = tog_cnt;
      pulse(1'b0);
      cap(1, tmr16_pkg::OFS_CC_B);
      sv_b = rd_q;
      rd(tmr16_pkg::OFS_CC_A);
      chk("a from primary", cnt_q - 32'h2, rd_q);
      chk("edge toggle", 32'h1, {16'h0, tog_cnt - t0});
      wr(tmr16_pkg::OFS_PRESC, 32'h2c);
      wr(tmr16_pkg::OFS_MODE, 32'h4);
      t0 = tog_cnt;
      pulse(1'b0);
      repeat (10) @(posedge sys_clk_in);
      chk("no capture toggle", 32'h0, {16'h0, tog_cnt - t0});
      rd(tmr16_pkg::OFS_CC_B);
      sv_b = rd_q;
      wr(tmr16_pkg::OFS_CCCTL, 32'h7);
      wr(tmr16_pkg::OFS_PRESC, 32'h38);
      pulse(1'b1);
      cap(0, tmr16_pkg::OFS_CC_A);
      rd(tmr16_pkg::OFS_CC_B);
      chk("b untouched", sv_b, rd_q);
      chk("output off", 32'h0, {31'h0, tog_pin});
      // counter is not writable, so a reset brings it back below the period
      rstn_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      rstn_in <= 1'b1;
      @(posedge sys_clk_in);
      rd(tmr16_pkg::OFS_COUNT);
      chk("count after reset", 32'h0, rd_q);
      wr(tmr16_pkg::OFS_OUTCTL, 32'h1);
      wr(tmr16_pkg::OFS_CCCTL, 32'h0);
      wr(tmr16_pkg::OFS_PRESC, 32'h28);
      wr(tmr16_pkg::OFS_CC_A, 32'h9);
      wr(tmr16_pkg::OFS_CC_B, 32'h3);
      wr(tmr16_pkg::OFS_MODE, 32'hc);
      run_len(1'b1);
      run_len(1'b0);
      run_len(1'b1);
      h = n;
      run_len(1'b0);
      chk("pulse high", 32'h4, h);
      chk("pulse period", 32'ha, h + n);
      report_and_stop();
   end
endmodule
